// file: logic/ibs_pkg.sv
package ibs_pkg;
  // Special function register addresses of the CPU-side registers
  localparam logic [7:0] ADDR_CHIP_CTRL = 8'h9F;
  localparam logic [7:0] ADDR_FL_ADDR_LO = 8'hAC;
  localparam logic [7:0] ADDR_FL_ADDR_HI = 8'hAD;
  localparam logic [7:0] ADDR_FL_DATA = 8'hAE;
  localparam logic [7:0] ADDR_FL_CMD = 8'hAF;
  localparam logic [7:0] ADDR_TIMED = 8'hC7;
  // Chip control values
  localparam logic [7:0] CHIP_ISP_LOADER = 8'h03;
  localparam logic [7:0] CHIP_ISP_STAY = 8'h01;
  localparam logic [7:0] CHIP_SW_RESET = 8'h83;
  localparam logic [7:0] CHIP_CTRL_RESET = 8'h00;
  // Flash commands
  localparam logic [7:0] CMD_ERASE_B0 = 8'h22;
  localparam logic [7:0] CMD_ERASE_B1 = 8'hA2;
  localparam logic [7:0] CMD_PROG_B0 = 8'h21;
  localparam logic [7:0] CMD_PROG_B1 = 8'hA1;
  localparam logic [7:0] CMD_RESET = 8'h00;
  // Timed access
  localparam logic [7:0] TIMED_KEY1 = 8'hAA;
  localparam logic [7:0] TIMED_KEY2 = 8'h55;
  localparam int CLK_PER_MC = 4;
  localparam int TIMED_WINDOW_MC = 3;
  localparam logic [3:0] TIMED_WINDOW_CYC = 4'(TIMED_WINDOW_MC * CLK_PER_MC);
  // Security option byte
  localparam logic [7:0] SEC_ERASED = 8'hFF;
  localparam int SEC_LOCK = 0;
  localparam int SEC_CODE_INHIBIT = 1;
  localparam int SEC_REBOOT_P2 = 4;
  localparam int SEC_REBOOT_P4 = 5;
  localparam int SEC_CLK_HIGH = 7;
  localparam int SYNC_STAGES = 3;

  typedef enum logic [1:0] {IBS_BANK_AP0, IBS_BANK_AP1, IBS_BANK_LD} ibs_bank_e;
  typedef enum {IBS_RUN, IBS_BUSY, IBS_DONE} ibs_state_e;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] data;
  } ibs_sfr_s;

  typedef struct packed {
    logic wr;
    logic erase_all;
    logic [7:0] data;
  } ibs_writer_s;

  typedef struct packed {
    logic go;
    logic erase;
    ibs_bank_e bank;
    logic [15:0] addr;
    logic [7:0] data;
  } ibs_flash_s;
endpackage

// file: logic/ibs_boot_security.sv
`timescale 1ns/100ps
// Notes on behaviour
// - Control 03h at idle from application: loader, reset.
// - Hardware reboot also starts from loader flash.
// - Writing 83h resets back to application flash.
// - Control 01h: finish update, keep running, no reset.
// - Command reaches loader or other bank accordingly.
// - Security byte reachable only in writer mode.
// - Programmed security bits stick until erase-all or module reset.
// - Security byte erased value is all ones.
// - Lock bit zero refuses external flash access.
// - Inhibit zero: external code reads stay external.
// - Internal code reads reach everything always.
// - Inhibit one: no code read restriction.
// - Bit4 zero, reset, port2 bits low: reboot.
// - Bit5 zero, reset, port4 bit3 low: reboot.
// - Control writes only inside timed window.
// - Command 22h/A2h erases bank 0/1.
// - Command 21h/A1h programs byte into bank 0/1.
module ibs_boot_security
  import ibs_pkg::*;
(
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RST_N,
  // CPU special function register bus
  input wire ibs_sfr_s I_SFR,
  output logic [7:0] O_SFR_RDATA,
  input wire logic I_CPU_IDLE,
  input wire logic I_CODE_FROM_EXT,
  // Pins sampled at reset
  input wire logic I_RST_PIN,
  input wire logic I_PORT2_BIT6,
  input wire logic I_PORT2_BIT7,
  input wire logic I_PORT4_BIT3,
  // Writer mode
  input wire logic I_WRITER_MODE,
  input wire ibs_writer_s I_WRITER,
  output logic [7:0] O_WRITER_RDATA,
  output logic O_WRITER_DENIED,
  // Flash engine
  output ibs_flash_s O_FLASH,
  input wire logic I_FLASH_DONE,
  // Core control
  output logic O_RUN_LOADER,
  output logic O_CPU_RESET,
  output logic O_CPU_HOLD,
  output logic O_CODE_READ_INT_OK,
  output logic O_CLK_HIGH
);
  logic [7:0] chip_ctrl;
  logic [7:0] fl_cmd;
  logic [7:0] fl_lo;
  logic [7:0] fl_hi;
  logic [7:0] fl_data;
  logic [7:0] security;
  logic run_loader;
  logic cpu_reset;
  logic win_armed;
  logic win_open;
  logic [3:0] win_cnt;
  logic idle_q;
  logic idle_rise;
  ibs_state_e state;
  ibs_flash_s flash;
  logic [SYNC_STAGES-1:0] s_rst;
  logic [SYNC_STAGES-1:0] s_p26;
  logic [SYNC_STAGES-1:0] s_p27;
  logic [SYNC_STAGES-1:0] s_p43;
  logic rst_pin;
  logic p26;
  logic p27;
  logic p43;
  logic reboot_req;
  logic chip_wr;
  ibs_bank_e bank;

  // Pin synchronisers: change accepted when stages two and three agree
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      s_rst <= '0;
      s_p26 <= '1;
      s_p27 <= '1;
      s_p43 <= '1;
    end else begin
      s_rst <= {s_rst[1:0], I_RST_PIN};
      s_p26 <= {s_p26[1:0], I_PORT2_BIT6};
      s_p27 <= {s_p27[1:0], I_PORT2_BIT7};
      s_p43 <= {s_p43[1:0], I_PORT4_BIT3};
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      rst_pin <= 1'b0;
      p26 <= 1'b1;
      p27 <= 1'b1;
      p43 <= 1'b1;
    end else begin
      if (s_rst[1] == s_rst[2]) rst_pin <= s_rst[2];
      if (s_p26[1] == s_p26[2]) p26 <= s_p26[2];
      if (s_p27[1] == s_p27[2]) p27 <= s_p27[2];
      if (s_p43[1] == s_p43[2]) p43 <= s_p43[2];
    end
  end

  assign reboot_req = rst_pin && ((!security[SEC_REBOOT_P2] && !p26 && !p27)
                      || (!security[SEC_REBOOT_P4] && !p43));

  // Timed access window: AAh arms, 55h within the window opens it
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      win_armed <= 1'b0;
      win_open <= 1'b0;
      win_cnt <= '0;
    end else if (I_SFR.wr && I_SFR.addr == ADDR_TIMED && I_SFR.data == TIMED_KEY1) begin
      win_armed <= 1'b1;
      win_open <= 1'b0;
      win_cnt <= TIMED_WINDOW_CYC;
    end else if (I_SFR.wr && I_SFR.addr == ADDR_TIMED && I_SFR.data == TIMED_KEY2 && win_armed) begin
      win_armed <= 1'b0;
      win_open <= 1'b1;
      win_cnt <= TIMED_WINDOW_CYC;
    end else if (win_cnt > 4'h0) begin
      win_cnt <= win_cnt - 4'h1;
    end else begin
      win_armed <= 1'b0;
      win_open <= 1'b0;
    end
  end

  assign chip_wr = I_SFR.wr && I_SFR.addr == ADDR_CHIP_CTRL && win_open;

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N || cpu_reset) begin
      chip_ctrl <= CHIP_CTRL_RESET;
    end else if (chip_wr && I_SFR.data != CHIP_SW_RESET) begin
      chip_ctrl <= I_SFR.data;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      fl_cmd <= CMD_RESET;
      fl_lo <= 8'h00;
      fl_hi <= 8'h00;
      fl_data <= 8'h00;
    end else if (I_SFR.wr) begin
      if (I_SFR.addr == ADDR_FL_CMD) fl_cmd <= I_SFR.data;
      else if (I_SFR.addr == ADDR_FL_ADDR_LO) fl_lo <= I_SFR.data;
      else if (I_SFR.addr == ADDR_FL_ADDR_HI) fl_hi <= I_SFR.data;
      else if (I_SFR.addr == ADDR_FL_DATA) fl_data <= I_SFR.data;
    end
  end

  // Read data is registered: it stands the cycle after the address is shown
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) O_SFR_RDATA <= 8'h00;
    else if (I_SFR.addr == ADDR_CHIP_CTRL) O_SFR_RDATA <= chip_ctrl;
    else if (I_SFR.addr == ADDR_FL_CMD) O_SFR_RDATA <= fl_cmd;
    else if (I_SFR.addr == ADDR_FL_ADDR_LO) O_SFR_RDATA <= fl_lo;
    else if (I_SFR.addr == ADDR_FL_ADDR_HI) O_SFR_RDATA <= fl_hi;
    else if (I_SFR.addr == ADDR_FL_DATA) O_SFR_RDATA <= fl_data;
    else O_SFR_RDATA <= 8'h00;
  end

  // Bank: from the loader, bit 7 picks bank 0 or 1; from the application the other bank or loader
  always_comb begin
    if (run_loader || chip_ctrl == CHIP_ISP_LOADER) begin
      bank = fl_cmd[7] ? IBS_BANK_AP1 : IBS_BANK_AP0;
    end else if (fl_cmd[7]) begin
      bank = IBS_BANK_AP1;
    end else if (fl_cmd[6]) begin
      bank = IBS_BANK_LD;
    end else begin
      bank = IBS_BANK_AP0;
    end
  end

  // Idle entry under 01h, or under 03h in the loader, launches one flash operation; CPU held until it finishes
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) idle_q <= 1'b0;
    else idle_q <= I_CPU_IDLE;
  end
  assign idle_rise = I_CPU_IDLE && !idle_q;

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      state <= IBS_RUN;
      flash <= '0;
    end else begin
      flash.go <= 1'b0;
      case (state)
        IBS_RUN: begin
          if (idle_rise && (chip_ctrl == CHIP_ISP_STAY || (chip_ctrl == CHIP_ISP_LOADER && run_loader))) begin
            flash.go <= 1'b1;
            flash.erase <= (fl_cmd == CMD_ERASE_B0 || fl_cmd == CMD_ERASE_B1);
            flash.bank <= bank;
            flash.addr <= {fl_hi, fl_lo};
            flash.data <= fl_data;
            state <= IBS_BUSY;
          end
        end
        IBS_BUSY: begin
          if (I_FLASH_DONE) state <= IBS_DONE;
        end
        IBS_DONE: begin
          if (!I_CPU_IDLE) state <= IBS_RUN;
        end
        default: state <= IBS_RUN;
      endcase
    end
  end
  assign O_FLASH = flash;
  assign O_CPU_HOLD = (state == IBS_BUSY);

  // Bank switching and CPU reset
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      run_loader <= 1'b0;
      cpu_reset <= 1'b0;
    end else begin
      cpu_reset <= 1'b0;
      if (reboot_req) begin
        run_loader <= 1'b1;
        cpu_reset <= 1'b1;
      end else if (chip_wr && I_SFR.data == CHIP_SW_RESET) begin
        run_loader <= 1'b0;
        cpu_reset <= 1'b1;
      end else if (idle_rise && !run_loader && chip_ctrl == CHIP_ISP_LOADER) begin
        run_loader <= 1'b1;
        cpu_reset <= 1'b1;
      end
    end
  end
  assign O_RUN_LOADER = run_loader;
  assign O_CPU_RESET = cpu_reset;

  // Security byte: writes only clear bits; erase-all restores ones
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      security <= SEC_ERASED;
    end else if (I_WRITER_MODE && I_WRITER.erase_all) begin
      security <= SEC_ERASED;
    end else if (I_WRITER_MODE && I_WRITER.wr && security[SEC_LOCK]) begin
      security <= security & I_WRITER.data;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      O_WRITER_RDATA <= 8'h00;
      O_WRITER_DENIED <= 1'b0;
    end else begin
      O_WRITER_DENIED <= I_WRITER_MODE && !security[SEC_LOCK];
      O_WRITER_RDATA <= (I_WRITER_MODE && security[SEC_LOCK]) ? security : 8'h00;
    end
  end

  // Code-table reads: from internal memory always allowed
  assign O_CODE_READ_INT_OK = !I_CODE_FROM_EXT || security[SEC_CODE_INHIBIT];
  assign O_CLK_HIGH = security[SEC_CLK_HIGH];

  AST_WINDOW_GATE: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    (I_SFR.wr && I_SFR.addr == ADDR_CHIP_CTRL && !win_open) |=> $stable(chip_ctrl) || chip_ctrl == CHIP_CTRL_RESET)
    else $error("control changed outside timed window");
  AST_SOFT_RESET: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    (chip_wr && I_SFR.data == CHIP_SW_RESET && !reboot_req) |=> cpu_reset && !run_loader)
    else $error("software reset did not return to application");
  AST_IDLE_LOADER: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    (idle_rise && !run_loader && chip_ctrl == CHIP_ISP_LOADER && !reboot_req && !chip_wr) |=> run_loader && cpu_reset)
    else $error("idle did not switch to loader");
  AST_STAY: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    (idle_rise && chip_ctrl == CHIP_ISP_STAY && !reboot_req && !chip_wr) |=> !cpu_reset && $stable(run_loader))
    else $error("stay mode switched or reset");
  AST_REBOOT: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    reboot_req |=> run_loader)
    else $error("hardware reboot did not select loader");
  AST_STICKY: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    !(I_WRITER_MODE && I_WRITER.erase_all) |=> ((security & ~$past(security)) == 8'h00))
    else $error("security bit returned to one without erase-all");
  AST_LOCK: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    (I_WRITER_MODE && !security[SEC_LOCK]) |=> O_WRITER_DENIED && O_WRITER_RDATA == 8'h00)
    else $error("locked device answered writer");
  AST_HOLD: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    (flash.go || (O_CPU_HOLD && !I_FLASH_DONE)) |=> O_CPU_HOLD)
    else $error("cpu not held during flash operation");
  AST_INHIBIT: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    (I_CODE_FROM_EXT && !security[SEC_CODE_INHIBIT]) |-> !O_CODE_READ_INT_OK)
    else $error("external code read reached internal flash");
  COV_SOFT_RESET: cover property (@(posedge I_CLK) chip_wr && I_SFR.data == CHIP_SW_RESET);
  COV_LAUNCH: cover property (@(posedge I_CLK) flash.go ##[1:50] I_FLASH_DONE);
  COV_REBOOT: cover property (@(posedge I_CLK) reboot_req);
  COV_LOCK: cover property (@(posedge I_CLK) !security[SEC_LOCK]);
endmodule

// file: tb/ibs_flash_model.sv
`timescale 1ns/100ps
module ibs_flash_model
  import ibs_pkg::*;
(
  // Clock
  input wire logic I_CLK,
  // Flash request and completion
  input wire ibs_flash_s I_FLASH,
  input wire logic [3:0] I_LAT,
  output logic O_DONE
);
  logic [3:0] cnt;
  logic busy;
  initial begin
    busy = 1'b0;
    cnt = 4'h0;
    O_DONE = 1'b0;
  end
  // Wait varies per request so the hold span is not a fixed figure
  always @(posedge I_CLK) begin
    O_DONE <= 1'b0;
    if (I_FLASH.go) begin
      busy <= 1'b1;
      cnt <= I_LAT;
    end else if (busy) begin
      if (cnt == 4'h0) begin
        O_DONE <= 1'b1;
        busy <= 1'b0;
      end else begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule

// file: tb/tb.sv
`timescale 1ns/100ps
module tb
  import ibs_pkg::*;
;
  logic I_CLK, I_RST_N, idle, ext, rpin, p26, p27, p43, wmode, done, run_ld, cpu_rst, hold, int_ok, clk_hi, denied;
  logic [3:0] lat;
  logic [7:0] sfr_rd, w_rd;
  logic [15:0] seed, a, d;
  ibs_sfr_s sfr;
  ibs_writer_s wr;
  ibs_flash_s fl, cap;
  int failures, total_checks;
  bit sr, sg, sh;
  logic [7:0] cmds [4];
  ibs_boot_security dut_u (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_SFR(sfr), .O_SFR_RDATA(sfr_rd),
    .I_CPU_IDLE(idle), .I_CODE_FROM_EXT(ext), .I_RST_PIN(rpin), .I_PORT2_BIT6(p26), .I_PORT2_BIT7(p27),
    .I_PORT4_BIT3(p43), .I_WRITER_MODE(wmode), .I_WRITER(wr), .O_WRITER_RDATA(w_rd),
    .O_WRITER_DENIED(denied), .O_FLASH(fl), .I_FLASH_DONE(done), .O_RUN_LOADER(run_ld),
    .O_CPU_RESET(cpu_rst), .O_CPU_HOLD(hold), .O_CODE_READ_INT_OK(int_ok), .O_CLK_HIGH(clk_hi));
  ibs_flash_model flash_u (.I_CLK(I_CLK), .I_FLASH(fl), .I_LAT(lat), .O_DONE(done));
  initial begin
    I_CLK = 1'b0;
    forever #10 I_CLK = ~I_CLK;
  end
  function automatic logic [15:0] rnd();
    seed ^= seed << 7;
    seed ^= seed >> 9;
    seed ^= seed << 8;
    return seed;
  endfunction
  function automatic logic [1:0] exp_bank(logic [7:0] c, logic ld);
    return c[7] ? 2'h1 : ((!ld && c[6]) ? 2'h2 : 2'h0);
  endfunction
  task automatic chk(input string n, input logic [17:0] e, input logic [17:0] g);
    total_checks++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", n, e, g);
      failures++;
    end
  endtask
  task automatic test_done();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic wsfr(input logic [7:0] ad, input logic [7:0] dt);
    @(posedge I_CLK);
    sfr <= '{1'b1, ad, dt};
    @(posedge I_CLK);
    sfr <= '{1'b0, ad, dt};
  endtask
  task automatic rsfr(input logic [7:0] ad);
    @(posedge I_CLK);
    sfr <= '{1'b0, ad, 8'h00};
    @(posedge I_CLK);
    @(negedge I_CLK);
  endtask
  task automatic ctl(input logic [7:0] v);
    wsfr(ADDR_TIMED, TIMED_KEY1);
    wsfr(ADDR_TIMED, TIMED_KEY2);
    wsfr(ADDR_CHIP_CTRL, v);
  endtask
  task automatic go_idle();
    sr = 0;
    sg = 0;
    sh = 0;
    @(posedge I_CLK);
    idle <= 1'b1;
    repeat (40) begin
      @(negedge I_CLK);
      sr |= cpu_rst;
      sh |= hold;
      if (fl.go) begin
        sg = 1;
        cap = fl;
      end
    end
    @(posedge I_CLK);
    idle <= 1'b0;
  endtask
  task automatic wsec(input logic we, input logic ea, input logic [7:0] v);
    @(posedge I_CLK);
    wr <= '{we, ea, v};
    @(posedge I_CLK);
    wr <= '{1'b0, 1'b0, v};
    repeat (3) @(negedge I_CLK);
  endtask
  initial begin
    repeat (20000) @(posedge I_CLK);
    failures++;
    test_done();
  end
  initial begin
    failures = 0;
    total_checks = 0;
    seed = 16'h003F;
    cmds = '{CMD_ERASE_B0, CMD_ERASE_B1, CMD_PROG_B0, CMD_PROG_B1};
    {I_RST_N, idle, ext, rpin, wmode, lat} = '0;
    {p26, p27, p43} = 3'b111;
    sfr = '0;
    wr = '0;
    repeat (3) @(posedge I_CLK);
    I_RST_N <= 1'b1;
    repeat (4) @(posedge I_CLK);
    wsec(1'b1, 1'b0, 8'hFD);
    chk("rdata off", 8'h00, w_rd);
    wmode <= 1'b1;
    wsec(1'b0, 1'b0, 8'h00);
    chk("sec erased", SEC_ERASED, w_rd);
    chk("clk high", 1'b1, clk_hi);
    $display("test reset done");
    wsfr(ADDR_CHIP_CTRL, CHIP_ISP_LOADER);
    rsfr(ADDR_CHIP_CTRL);
    chk("ctrl closed", CHIP_CTRL_RESET, sfr_rd);
    ctl(CHIP_ISP_LOADER);
    rsfr(ADDR_CHIP_CTRL);
    chk("ctrl open", CHIP_ISP_LOADER, sfr_rd);
    go_idle();
    chk("sw to loader rst", 1'b1, sr);
    chk("loader", 1'b1, run_ld);
    $display("test enter loader done");
    for (int i = 0; i < 4; i++) begin
      a = rnd();
      d = rnd();
      lat <= d[11:8];
      wsfr(ADDR_FL_ADDR_LO, a[7:0]);
      wsfr(ADDR_FL_ADDR_HI, a[15:8]);
      wsfr(ADDR_FL_DATA, d[7:0]);
      wsfr(ADDR_FL_CMD, cmds[i]);
      ctl(CHIP_ISP_LOADER);
      go_idle();
      chk("go", 1'b1, sg);
      chk("bank", exp_bank(cmds[i], 1'b1), cap.bank);
      chk("erase", cmds[i][1], cap.erase);
      chk("addr", a, cap.addr);
      if (!cmds[i][1]) chk("data", d[7:0], cap.data);
      chk("held", 1'b1, sh);
      chk("released", 1'b0, hold);
      chk("stays loader", 1'b1, run_ld);
    end
    $display("test loader commands done");
    ctl(CHIP_SW_RESET);
    repeat (3) @(negedge I_CLK);
    chk("back to app", 1'b0, run_ld);
    rsfr(ADDR_CHIP_CTRL);
    chk("ctrl cleared", CHIP_CTRL_RESET, sfr_rd);
    wsfr(ADDR_FL_DATA, 8'h5A);
    wsfr(ADDR_FL_CMD, 8'h61);
    rsfr(ADDR_FL_CMD);
    chk("cmd rd", 8'h61, sfr_rd);
    ctl(CHIP_ISP_STAY);
    go_idle();
    chk("stay go", 1'b1, sg);
    chk("stay bank", exp_bank(8'h61, 1'b0), cap.bank);
    chk("stay data", 8'h5A, cap.data);
    chk("stay prog", 1'b0, cap.erase);
    chk("stay no rst", 1'b0, sr);
    chk("stay app", 1'b0, run_ld);
    $display("test stay mode done");
    ext <= 1'b1;
    wsec(1'b1, 1'b0, 8'hFD);
    chk("inhibit ext", 1'b0, int_ok);
    ext <= 1'b0;
    wsec(1'b1, 1'b0, 8'hFF);
    chk("inhibit int", 1'b1, int_ok);
    chk("sticky", 8'hFD, w_rd);
    ext <= 1'b1;
    wsec(1'b0, 1'b1, 8'h00);
    chk("erase all", SEC_ERASED, w_rd);
    chk("no inhibit", 1'b1, int_ok);
    $display("test security done");
    wsec(1'b1, 1'b0, 8'hEF);
    {rpin, p26, p27} <= 3'b100;
    repeat (12) @(negedge I_CLK);
    chk("reboot p2", 1'b1, run_ld);
    {rpin, p26, p27} <= 3'b011;
    ctl(CHIP_SW_RESET);
    wsec(1'b0, 1'b1, 8'h00);
    wsec(1'b1, 1'b0, 8'hDF);
    chk("app again", 1'b0, run_ld);
    {rpin, p43} <= 2'b10;
    repeat (12) @(negedge I_CLK);
    chk("reboot p4", 1'b1, run_ld);
    {rpin, p43} <= 2'b01;
    $display("test reboot done");
    wsec(1'b1, 1'b0, 8'hDE);
    chk("denied", 1'b1, denied);
    chk("locked rd", 8'h00, w_rd);
    chk("clk range", 1'b1, clk_hi);
    $display("test lock done");
    test_done();
  end
endmodule
